// ---- hbl_loader.sv ----
// Purpose: host serial slave, tuner pass-through, rom boot master, code store
// Assumes: pins synchronous to clk_sys_i; async_reset_n_i is asynchronous
// Notes: the rom is read from its current address after power-up
`timescale 1ns/1ns
`default_nettype none
module hbl_loader #(
  parameter int CODE_BYTES = 256,
  parameter int ROM_QTR = hbl_pkg::ROM_QTR_CYC
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic async_reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [1:0] slave_addr_lsb_straps_i,
  input wire logic rom_addr_lsb_strap_i,
  input wire logic boot_source_strap_i,
  input wire logic [3:0] test_select_bus_i,
  input wire logic scan_enable_i,
  input wire logic host_bus_clock_i,
  input wire logic host_bus_data_i,
  output logic host_bus_data_o,
  output logic host_bus_data_oe_o,
  output logic tuner_bus_clock_o,
  output logic tuner_bus_clock_oe_o,
  input wire logic tuner_bus_data_i,
  output logic tuner_bus_data_o,
  output logic tuner_bus_data_oe_o,
  output logic rom_bus_clock_o,
  output logic rom_bus_clock_oe_o,
  input wire logic rom_bus_data_i,
  output logic rom_bus_data_o,
  output logic rom_bus_data_oe_o,
  input wire logic [$clog2(CODE_BYTES)-1:0] code_rd_addr_i,
  output logic [7:0] code_rd_data_o,
  output logic dsp_run_o
);
  localparam int AW = $clog2(CODE_BYTES);
  localparam int WW = $clog2(CODE_BYTES + 1);
  logic clr;
  logic taken_q, boot_src_q, rom_lsb_q;
  logic [1:0] my_lsb_q;
  hbl_pkg::hbl_ahb_req_type req_d, req_q;
  logic pass_q;
  logic [31:0] status_w, rdata_d, hrdata_q;
  hbl_pkg::hbl_slv_state_type sl_st_q;
  logic [3:0] sl_bit_q;
  logic [7:0] sl_shift_q, sl_ptr_q;
  logic sl_first_q, host_clk_q, host_dat_q, ret_q;
  logic start_c, stop_c, rise_c, fall_c, addr_ok, host_wr;
  hbl_pkg::hbl_mst_state_type m_st_q;
  logic [15:0] m_cnt_q;
  logic [1:0] m_q_q;
  logic [3:0] m_bit_q;
  logic [7:0] m_shift_q;
  logic m_ack_q, rom_err_q, rom_clk_oe_q, rom_dat_oe_q, qtick, last, rom_wr;
  logic m_clk_oe_d, m_dat_oe_d;
  logic [7:0] code_mem_q [CODE_BYTES];
  logic [WW-1:0] wptr_q;
  logic [7:0] code_rd_q, wr_byte;
  logic wr_en, done, test_ok, dsp_run_q;

  assign clr = !resetn_i;

  // straps are caught on the first clock after reset, never inside the reset branch
  always_ff @(posedge clk_sys_i or negedge async_reset_n_i)
  begin
    if (!async_reset_n_i)
    begin
      taken_q <= 1'b0;
      boot_src_q <= 1'b0;
      my_lsb_q <= 2'h0;
      rom_lsb_q <= 1'b0;
    end
    else if (clr)
    begin
      taken_q <= 1'b0;
      boot_src_q <= 1'b0;
      my_lsb_q <= 2'h0;
      rom_lsb_q <= 1'b0;
    end
    else if (!taken_q)
    begin
      taken_q <= 1'b1;
      boot_src_q <= boot_source_strap_i;
      my_lsb_q <= slave_addr_lsb_straps_i;
      rom_lsb_q <= rom_addr_lsb_strap_i;
    end
  end

  // register bus: zero wait, read data prepared in the address phase
  assign req_d = '{valid: hsel_i & htrans_i[1] & hready_i, write: hwrite_i, addr: haddr_i};
  assign status_w = (32'(wptr_q) << hbl_pkg::ST_CNT_LSB) |
                    32'({dsp_run_q, rom_err_q, boot_src_q, done});
  assign rdata_d = !(req_d.valid && !req_d.write) ? hrdata_q :
                   (req_d.addr == hbl_pkg::CTRL_OFS) ? 32'(pass_q) :
                   (req_d.addr == hbl_pkg::STATUS_OFS) ? status_w : 32'h0000_0000;
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge clk_sys_i or negedge async_reset_n_i)
  begin
    if (!async_reset_n_i)
    begin
      req_q <= '0;
      hrdata_q <= 32'h0000_0000;
      pass_q <= hbl_pkg::CTRL_PASS_RST;
    end
    else if (clr)
    begin
      req_q <= '0;
      hrdata_q <= 32'h0000_0000;
      pass_q <= hbl_pkg::CTRL_PASS_RST;
    end
    else
    begin
      req_q <= req_d;
      hrdata_q <= rdata_d;
      if (req_q.valid && req_q.write && req_q.addr == hbl_pkg::CTRL_OFS)
        pass_q <= hwdata_i[hbl_pkg::CTRL_PASS_BIT];
    end
  end

  // tuner pass-through
  // the return path is registered and blocks the forward path to avoid a lock-up loop
  assign tuner_bus_clock_o = 1'b0;
  assign tuner_bus_data_o = 1'b0;
  assign tuner_bus_clock_oe_o = pass_q & !host_bus_clock_i;
  assign tuner_bus_data_oe_o = pass_q & !host_bus_data_i & !ret_q;

  // edges seen by sampling; 700 kbit/s leaves about 14 clocks per bit
  assign start_c = host_bus_clock_i & host_clk_q & host_dat_q & !host_bus_data_i;
  assign stop_c = host_bus_clock_i & host_clk_q & !host_dat_q & host_bus_data_i;
  assign rise_c = host_bus_clock_i & !host_clk_q;
  assign fall_c = !host_bus_clock_i & host_clk_q;
  assign addr_ok = (sl_shift_q[7:1] == {hbl_pkg::SLAVE_ADDR_HI, my_lsb_q}) && !sl_shift_q[0];
  // host bytes at the code-input sub-address feed the store
  assign host_wr = fall_c && sl_bit_q == 4'h8 && sl_st_q == hbl_pkg::SL_DATA && !sl_first_q &&
                   sl_ptr_q == hbl_pkg::CODE_IN_SUBADDR && boot_src_q && !done;
  assign host_bus_data_o = 1'b0;
  assign host_bus_data_oe_o = (sl_st_q == hbl_pkg::SL_ACK) | ret_q;

  always_ff @(posedge clk_sys_i or negedge async_reset_n_i)
  begin
    if (!async_reset_n_i)
    begin
      sl_st_q <= hbl_pkg::SL_IDLE;
      sl_bit_q <= 4'h0;
      sl_shift_q <= 8'h00;
      sl_ptr_q <= 8'h00;
      sl_first_q <= 1'b0;
      host_clk_q <= 1'b1;
      host_dat_q <= 1'b1;
      ret_q <= 1'b0;
    end
    else if (clr)
    begin
      sl_st_q <= hbl_pkg::SL_IDLE;
      sl_bit_q <= 4'h0;
      sl_shift_q <= 8'h00;
      sl_ptr_q <= 8'h00;
      sl_first_q <= 1'b0;
      host_clk_q <= 1'b1;
      host_dat_q <= 1'b1;
      ret_q <= 1'b0;
    end
    else
    begin
      host_clk_q <= host_bus_clock_i;
      host_dat_q <= host_bus_data_i;
      ret_q <= pass_q & !tuner_bus_data_i & !tuner_bus_data_oe_o;
      if (!taken_q || stop_c)
        sl_st_q <= hbl_pkg::SL_IDLE;
      else if (start_c)
      begin
        sl_st_q <= hbl_pkg::SL_ADDR;
        sl_bit_q <= 4'h0;
      end
      else if (rise_c && (sl_st_q == hbl_pkg::SL_ADDR || sl_st_q == hbl_pkg::SL_DATA))
      begin
        sl_shift_q <= {sl_shift_q[6:0], host_bus_data_i};
        sl_bit_q <= sl_bit_q + 4'h1;
      end
      else if (fall_c && sl_st_q == hbl_pkg::SL_ACK)
      begin
        sl_st_q <= hbl_pkg::SL_DATA;
        sl_bit_q <= 4'h0;
      end
      else if (fall_c && sl_bit_q == 4'h8)
      begin
        if (sl_st_q == hbl_pkg::SL_ADDR)
        begin
          sl_st_q <= addr_ok ? hbl_pkg::SL_ACK : hbl_pkg::SL_IDLE;
          sl_first_q <= 1'b1;
        end
        else if (sl_st_q == hbl_pkg::SL_DATA)
        begin
          sl_st_q <= hbl_pkg::SL_ACK;
          sl_first_q <= 1'b0;
          if (sl_first_q)
            sl_ptr_q <= sl_shift_q;
        end
      end
    end
  end

  // rom master: quarter-bit timing, clock low in quarters 0 and 1
  assign qtick = m_cnt_q == 16'(ROM_QTR - 1);
  assign last = wptr_q == WW'(CODE_BYTES - 1);
  assign rom_wr = qtick && m_q_q == 2'h3 && m_st_q == hbl_pkg::MS_READ && m_bit_q == 4'h8 && !done;
  assign m_clk_oe_d = !m_q_q[1] && (m_st_q == hbl_pkg::MS_ADDR || m_st_q == hbl_pkg::MS_READ ||
                                    m_st_q == hbl_pkg::MS_STOP);
  assign m_dat_oe_d = (m_st_q == hbl_pkg::MS_START) ? m_q_q[1] :
                      (m_st_q == hbl_pkg::MS_ADDR) ? (m_bit_q != 4'h8 && !m_shift_q[7]) :
                      (m_st_q == hbl_pkg::MS_READ) ? (m_bit_q == 4'h8 && !last) :
                      (m_st_q == hbl_pkg::MS_STOP) ? (m_q_q != 2'h3) : 1'b0;
  assign rom_bus_clock_o = 1'b0;
  assign rom_bus_data_o = 1'b0;
  assign rom_bus_clock_oe_o = rom_clk_oe_q;
  assign rom_bus_data_oe_o = rom_dat_oe_q;

  always_ff @(posedge clk_sys_i or negedge async_reset_n_i)
  begin
    if (!async_reset_n_i)
    begin
      m_st_q <= hbl_pkg::MS_WAIT;
      m_cnt_q <= 16'h0000;
      m_q_q <= 2'h0;
      m_bit_q <= 4'h0;
      m_shift_q <= 8'h00;
      m_ack_q <= 1'b0;
      rom_err_q <= 1'b0;
      rom_clk_oe_q <= 1'b0;
      rom_dat_oe_q <= 1'b0;
    end
    else if (clr)
    begin
      m_st_q <= hbl_pkg::MS_WAIT;
      m_cnt_q <= 16'h0000;
      m_q_q <= 2'h0;
      m_bit_q <= 4'h0;
      m_shift_q <= 8'h00;
      m_ack_q <= 1'b0;
      rom_err_q <= 1'b0;
      rom_clk_oe_q <= 1'b0;
      rom_dat_oe_q <= 1'b0;
    end
    else
    begin
      rom_clk_oe_q <= m_clk_oe_d;
      rom_dat_oe_q <= m_dat_oe_d;
      m_cnt_q <= qtick ? 16'h0000 : m_cnt_q + 16'h0001;
      if (m_st_q == hbl_pkg::MS_WAIT)
      begin
        m_cnt_q <= 16'h0000;
        m_q_q <= 2'h0;
        // read address: fixed bits, strap, read flag
        m_shift_q <= {hbl_pkg::ROM_ADDR_HI, rom_lsb_q, 1'b1};
        // rom load only for strap 0
        if (taken_q)
          m_st_q <= boot_src_q ? hbl_pkg::MS_IDLE : hbl_pkg::MS_START;
      end
      else if (qtick)
      begin
        m_q_q <= m_q_q + 2'h1;
        if (m_q_q == 2'h2 && m_st_q == hbl_pkg::MS_ADDR && m_bit_q == 4'h8)
          m_ack_q <= !rom_bus_data_i;
        if (m_q_q == 2'h2 && m_st_q == hbl_pkg::MS_READ && m_bit_q != 4'h8)
          m_shift_q <= {m_shift_q[6:0], rom_bus_data_i};
        if (m_q_q == 2'h3)
        begin
          case (m_st_q)
            hbl_pkg::MS_START:
            begin
              m_st_q <= hbl_pkg::MS_ADDR;
              m_bit_q <= 4'h0;
            end
            hbl_pkg::MS_ADDR:
              if (m_bit_q == 4'h8)
              begin
                // no retry: a missing rom leaves the dsp idle with the error flag up
                m_st_q <= m_ack_q ? hbl_pkg::MS_READ : hbl_pkg::MS_STOP;
                rom_err_q <= !m_ack_q;
                m_bit_q <= 4'h0;
              end
              else
              begin
                m_shift_q <= {m_shift_q[6:0], 1'b0};
                m_bit_q <= m_bit_q + 4'h1;
              end
            hbl_pkg::MS_READ:
              if (m_bit_q == 4'h8)
              begin
                m_bit_q <= 4'h0;
                if (last)
                  m_st_q <= hbl_pkg::MS_STOP;
              end
              else
                m_bit_q <= m_bit_q + 4'h1;
            hbl_pkg::MS_STOP:
              m_st_q <= hbl_pkg::MS_IDLE;
            default:
              m_st_q <= m_st_q;
          endcase
        end
      end
    end
  end

  // the store is filled from the strapped source only
  assign wr_en = host_wr | rom_wr;
  assign wr_byte = boot_src_q ? sl_shift_q : m_shift_q;
  assign done = wptr_q == WW'(CODE_BYTES);
  // test or scan straps active keep the dsp stopped
  assign test_ok = test_select_bus_i == 4'h0 && !scan_enable_i;
  assign code_rd_data_o = code_rd_q;
  assign dsp_run_o = dsp_run_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en)
      code_mem_q[wptr_q[AW-1:0]] <= wr_byte;
  end

  // async pin clears load state and run at once
  always_ff @(posedge clk_sys_i or negedge async_reset_n_i)
  begin
    if (!async_reset_n_i)
    begin
      wptr_q <= '0;
      code_rd_q <= 8'h00;
      dsp_run_q <= 1'b0;
    end
    else if (clr)
    begin
      wptr_q <= '0;
      code_rd_q <= 8'h00;
      dsp_run_q <= 1'b0;
    end
    else
    begin
      if (wr_en)
        wptr_q <= wptr_q + WW'(1);
      code_rd_q <= code_mem_q[code_rd_addr_i];
      // run only after the whole image is in
      dsp_run_q <= done && test_ok;
    end
  end

  slave_addr_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    (sl_st_q == hbl_pkg::SL_ACK && $past(sl_st_q) == hbl_pkg::SL_ADDR) |->
    $past(sl_shift_q) == {hbl_pkg::SLAVE_ADDR_HI, my_lsb_q, 1'b0})
    else $error("slave acked a foreign address");
  rom_addr_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    (m_st_q == hbl_pkg::MS_ADDR && $past(m_st_q) == hbl_pkg::MS_START) |->
    m_shift_q == {hbl_pkg::ROM_ADDR_HI, rom_lsb_q, 1'b1})
    else $error("wrong rom address byte");
  async_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !async_reset_n_i |-> (!dsp_run_o && wptr_q == '0 && !rom_bus_clock_oe_o))
    else $error("state alive during async reset");
  rom_only_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    rom_bus_clock_oe_o |-> (taken_q && !boot_src_q))
    else $error("rom bus clocked in host boot mode");
  host_code_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    host_wr |=> (wptr_q == $past(wptr_q) + WW'(1) && boot_src_q))
    else $error("host code byte not stored");
  tuner_off_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    !pass_q ##1 !pass_q |-> (!tuner_bus_clock_oe_o && !tuner_bus_data_oe_o && !ret_q))
    else $error("tuner bus driven while disconnected");
  one_path_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    wr_en |-> (!done && !(host_wr && rom_wr) && (rom_wr != boot_src_q)))
    else $error("code written from wrong path");
  run_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || !async_reset_n_i)
    ($rose(done) && test_ok |=> dsp_run_o) and (dsp_run_o |-> $past(done)))
    else $error("dsp start not tied to load done");
endmodule
`default_nettype wire

// ---- hbl_pkg.sv ----
// Purpose: shared constants, state codes and carrier types for the boot loader
// Assumes: 10 MHz system clock
// Notes: offsets are byte addresses on the register bus
`default_nettype none
package hbl_pkg;
  // fixed upper bits of the two bus addresses
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h02;
  localparam logic [5:0] ROM_ADDR_HI = 6'h28;
  // host clocking tops out at 700 kbit/s, about 14 system clocks per bit
  localparam int HOST_MAX_KBPS = 700;
  localparam int CLK_NS = 100;
  // rom bus bit time, split into four quarters; least time rounds up
  localparam int ROM_BIT_NS = 10000;
  localparam int ROM_QTR_CYC = (ROM_BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
  // host sub-address of the code-input register
  localparam logic [7:0] CODE_IN_SUBADDR = 8'h00;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam int CTRL_PASS_BIT = 0;
  localparam logic CTRL_PASS_RST = 1'b0;
  localparam int ST_CNT_LSB = 16;
  typedef enum logic [3:0] {
    SL_IDLE = 4'h1,
    SL_ADDR = 4'h2,
    SL_DATA = 4'h4,
    SL_ACK = 4'h8
  } hbl_slv_state_type;
  typedef enum logic [5:0] {
    MS_WAIT = 6'h01,
    MS_START = 6'h02,
    MS_ADDR = 6'h04,
    MS_READ = 6'h08,
    MS_STOP = 6'h10,
    MS_IDLE = 6'h20
  } hbl_mst_state_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } hbl_ahb_req_type;
endpackage
`default_nettype wire

// ---- hbl_rom_model.sv ----
// Purpose: serial rom on the boot bus, sends a four byte image
// Assumes: bench resolves the open-drain wires, pull-up when released
// Notes: current-address reads only; a master nack ends the stream
`timescale 1ns/1ns
`default_nettype none
module hbl_rom_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] dev_i,
  input wire logic [31:0] image_i,
  output logic sda_oe_o
);
  logic [7:0] sh;
  logic more;
  int idx;
  initial
  begin
    sda_oe_o = 1'b0;
    forever
    begin
      // data may fall with the clock in one step, so recheck the clock later
      @(negedge sda_i);
      #1;
      if (scl_i !== 1'b1)
        continue;
      for (int i = 0; i < 8; i++)
      begin
        @(posedge scl_i);
        sh = {sh[6:0], sda_i};
      end
      @(negedge scl_i);
      if (sh !== {dev_i, 1'b1})
        continue;
      sda_oe_o = 1'b1;
      idx = 0;
      more = 1'b1;
      while (more)
      begin
        @(negedge scl_i);
        for (int i = 7; i >= 0; i--)
        begin
          sda_oe_o = !image_i[8 * (3 - idx % 4) + i];
          @(negedge scl_i);
        end
        sda_oe_o = 1'b0;
        @(posedge scl_i);
        more = !sda_i;
        idx++;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the boot loader
// Assumes: host master clocks 16 system clocks per bit
// Notes: four byte store and short rom bit keep the run brief
`timescale 1ns/1ns
`default_nettype none
`define chk(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module testbench;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, async_reset_n_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, cr_v = 1'b0, cr_d = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, e, s, image, hcode;
  logic [1:0] htrans = 2'h0, sa = 2'h0, caddr = 2'h0;
  logic ra = 1'b0, src = 1'b0, scan = 1'b0, rom_bad = 1'b0, h_scl = 1'b1, h_sda = 1'b1;
  logic pass_exp = 1'b0, hready, hresp_o, hdoe, tcoe, tdoe, rcoe, rdoe, rom_oe, dsp_run_o;
  logic [3:0] tsel = 4'h0;
  logic [31:0] hrdata_o;
  logic [7:0] code_rd_data_o;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0;
  wire logic host_sda = h_sda & !hdoe;
  wire logic rom_sda = !(rdoe | rom_oe);
  hbl_loader #(.CODE_BYTES(4), .ROM_QTR(2)) i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .async_reset_n_i(async_reset_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata_o), .hreadyout_o(hready), .hresp_o(hresp_o),
    .slave_addr_lsb_straps_i(sa), .rom_addr_lsb_strap_i(ra), .boot_source_strap_i(src),
    .test_select_bus_i(tsel), .scan_enable_i(scan), .host_bus_clock_i(h_scl),
    .host_bus_data_i(host_sda), .host_bus_data_o(), .host_bus_data_oe_o(hdoe),
    .tuner_bus_clock_o(), .tuner_bus_clock_oe_o(tcoe), .tuner_bus_data_i(!tdoe),
    .tuner_bus_data_o(), .tuner_bus_data_oe_o(tdoe), .rom_bus_clock_o(),
    .rom_bus_clock_oe_o(rcoe), .rom_bus_data_i(rom_sda), .rom_bus_data_o(),
    .rom_bus_data_oe_o(rdoe), .code_rd_addr_i(caddr), .code_rd_data_o(code_rd_data_o),
    .dsp_run_o(dsp_run_o));
  hbl_rom_model i_rom (.scl_i(!rcoe), .sda_i(rom_sda), .dev_i({6'h28, ra ^ rom_bad}),
    .image_i(image), .sda_oe_o(rom_oe));
  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task tk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do tk(1); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_ph <= !w;
    do tk(1); while (hready !== 1'b1);
    rd_ph <= 1'b0;
    `chk("resp", 1'b0, hresp_o)
  endtask
  task cread(input logic [1:0] i, input logic [7:0] d);
    exp_q.push_back({24'h0, d});
    caddr <= i;
    cr_v <= 1'b1;
    tk(1);
    cr_v <= 1'b0;
    tk(1);
  endtask
  task rst(input logic bs, input logic bad);
    resetn_i <= 1'b0;
    src <= bs;
    rom_bad <= bad;
    sa <= 2'($urandom);
    ra <= 1'($urandom);
    pass_exp = 1'b0;
    tk(16);
    resetn_i <= 1'b1;
    tk(1);
    `chk("dsp idle", 1'b0, dsp_run_o)
  endtask
  task wrun;
    for (int i = 0; i < 3000 && dsp_run_o !== 1'b1; i++)
      tk(1);
    `chk("dsp run", 1'b1, dsp_run_o)
  endtask
  // host master stays at 625 kbit/s
  task hbit(input logic b);
    h_sda <= b;
    tk(4);
    `chk("tuner clk", pass_exp, tcoe)
    `chk("tuner data", pass_exp & !b, tdoe)
    h_scl <= 1'b1;
    tk(8);
    h_scl <= 1'b0;
    tk(4);
  endtask
  task hbyte(input logic [7:0] b, input logic ea);
    for (int i = 7; i >= 0; i--)
      hbit(b[i]);
    h_sda <= 1'b1;
    tk(4);
    h_scl <= 1'b1;
    tk(4);
    `chk("ack", ea, hdoe)
    `chk("rom idle", 1'b0, rcoe)
    tk(4);
    h_scl <= 1'b0;
    tk(4);
  endtask
  always @(posedge clk_sys_i)
  begin
    cr_d <= cr_v;
    if ((rd_ph && hready === 1'b1) || cr_d)
    begin
      e = exp_q.pop_front();
      s = rd_ph ? hrdata_o : {24'h0, code_rd_data_o};
      `chk("read", e, s)
    end
  end
  initial
  begin
    #(30000 * 100);
    n_mismatch++;
    results();
  end
  initial
  begin
    void'($urandom(32'h842E27F6));
    image = $urandom;
    hcode = $urandom;
    tk(1);
    // wrong rom address: nack, error bit, no run
    rst(1'b0, 1'b1);
    tk(400);
    ahb(1'b0, hbl_pkg::STATUS_OFS, 32'h4);
    `chk("dsp stays idle", 1'b0, dsp_run_o)
    rst(1'b0, 1'b0);
    wrun();
    ahb(1'b0, hbl_pkg::STATUS_OFS, (32'h4 << hbl_pkg::ST_CNT_LSB) | 32'h9);
    for (int i = 0; i < 4; i++)
      cread(2'(i), image[8 * (3 - i) +: 8]);
    // test inputs held at zero except here
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        tsel <= 4'($urandom_range(15, 1));
      else
        scan <= 1'b1;
      tk(3);
      `chk("dsp held", 1'b0, dsp_run_o)
      tsel <= 4'h0;
      scan <= 1'b0;
      tk(3);
      `chk("dsp resumes", 1'b1, dsp_run_o)
    end
    #30 async_reset_n_i = 1'b0;
    #1 `chk("async reset", 1'b0, dsp_run_o)
    tk(5);
    `chk("reset holds", 1'b0, dsp_run_o)
    async_reset_n_i <= 1'b1;
    wrun();
    // host load: foreign address, read bit, then the real frame
    rst(1'b1, 1'b0);
    ahb(1'b0, hbl_pkg::CTRL_OFS, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      h_sda <= 1'b0;
      tk(8);
      h_scl <= 1'b0;
      tk(4);
      hbyte(k == 0 ? {5'h03, sa, 1'b0} : {5'h02, sa, k == 1}, k == 2);
      if (k == 2)
        hbyte(hbl_pkg::CODE_IN_SUBADDR, 1'b1);
      for (int j = 0; j < 4 && k == 2; j++)
        hbyte(hcode[8 * (3 - j) +: 8], 1'b1);
      h_sda <= 1'b0;
      tk(4);
      h_scl <= 1'b1;
      tk(8);
      h_sda <= 1'b1;
      tk(8);
      if (k == 1)
        ahb(1'b1, hbl_pkg::CTRL_OFS, 32'h1);
      pass_exp = (k == 1);
    end
    wrun();
    ahb(1'b0, hbl_pkg::STATUS_OFS, (32'h4 << hbl_pkg::ST_CNT_LSB) | 32'hB);
    for (int i = 0; i < 4; i++)
      cread(2'(i), hcode[8 * (3 - i) +: 8]);
    tk(4);
    results();
  end
endmodule
`default_nettype wire
